// *** design/csg_core.sv ***
// Current-sense gating and overcurrent reaction core
// How it works
// - Always-off mode keeps every sense output disconnected.
// - Low-side-on mode connects a sense output while its low gate is on.
// - Single shunt low-side-on connects on the OR of low gates.
// - With several amplifiers, each output follows its own low gate.
// - High-side-off mode connects during low-side on and both dead times.
// - Always-on mode keeps enabled amplifier outputs connected.
// - Blanking disconnects inputs after switching, zero or 50 ns to 8 us.
// - Offset chooses one half, five twelfths, one third or one quarter.
// - Truncation cuts PWM at once and reports fault, no deglitch.
// - No-report option truncates PWM without asserting the fault pin.
// - Brake option starts braking on overcurrent instead of truncating.
// - Disabled protection neither truncates nor reports.
// - Latched fault holds fault pin low until clear command.
// - Non-latched fault pin follows the detected condition.
// - Fault reported only after target count of consecutive event cycles.
// - In truncate and no-report modes a positive event turns off all high sides for rest of cycle.
// - Each amplifier is enabled on its own.
// - Gain defaults to 4, selectable 8,12,14,20,24,32,63.
`timescale 1ns/1ps
`default_nettype none

module csg_core
  import csg_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Gate drive pins and cycle marker
  input  wire csg_gates_t gates_in,
  input  wire logic       pwm_cycle_start,
  // Overcurrent comparator
  input  wire logic       ocp_pos_event,
  // Configuration and host command
  input  wire csg_cfg_t   cfg,
  input  wire logic       fault_clear,
  // Outputs
  output logic [2:0]      sense_output_n_conn,
  output logic [2:0]      high_side_gate_n_out,
  output logic [2:0]      low_side_gate_n_out,
  output logic            brake_req,
  output logic            fault_out_n,
  output logic [5:0]      gain_value,
  output logic [1:0]      offset_code
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    csg_gates_t             g1;
    csg_gates_t             g2;
    logic                   ev1;
    logic                   ev2;
    logic                   cyc1;
    logic                   cyc2;
    csg_gates_t             gprev;
    logic [CSG_BLANK_W-1:0] blank;
    logic                   trunc;
    logic                   cyc_ev;
    logic [CSG_CNT_W-1:0]   cnt;
    logic                   fault;
    logic [2:0]             conn;
    logic [2:0]             hs_out;
    logic [2:0]             ls_out;
    logic                   brake;
    logic                   fault_n;
    logic [5:0]             gain;
    logic [1:0]             offs;
  } csg_state_t;

  csg_state_t st_r;
  csg_state_t st_nxt;

  // Gain code to value
  function automatic logic [5:0] gain_of(input logic [2:0] sel);
    case (sel)
      3'h1:    gain_of = 6'h08;
      3'h2:    gain_of = 6'h0C;
      3'h3:    gain_of = 6'h0E;
      3'h4:    gain_of = 6'h14;
      3'h5:    gain_of = 6'h18;
      3'h6:    gain_of = 6'h20;
      3'h7:    gain_of = 6'h3F;
      default: gain_of = 6'h04;
    endcase
  endfunction : gain_of

  logic [2:0] lsg;
  logic [2:0] hsg;
  logic [2:0] want;
  logic       switched;
  logic       blanking;
  logic       cyc_ok;
  logic       reached;

  always_comb begin
    st_nxt = st_r;
    // Pins pass two flip-flops before use
    st_nxt.g1   = gates_in;
    st_nxt.g2   = st_r.g1;
    st_nxt.ev1  = ocp_pos_event;
    st_nxt.ev2  = st_r.ev1;
    st_nxt.cyc1 = pwm_cycle_start;
    st_nxt.cyc2 = st_r.cyc1;
    st_nxt.gprev = st_r.g2;
    lsg = st_r.g2.low_side_gate_n;
    hsg = st_r.g2.high_side_gate_n;
    switched = (st_r.g2 != st_r.gprev);

    // Window after switching, zero length when count is zero
    if (switched && cfg.blank_cyc != 8'h00) begin
      st_nxt.blank = cfg.blank_cyc;
    end else if (st_r.blank != 8'h00) begin
      st_nxt.blank = st_r.blank - 8'h01;
    end
    blanking = switched ? (cfg.blank_cyc != 8'h00) : (st_r.blank != 8'h00);

    case (cfg.mode)
      CSG_MODE_OFF:   want = 3'h0;
      CSG_MODE_LSON:  want = cfg.single_shunt ? {3{|lsg}}
                                              : lsg;
      CSG_MODE_HSOFF: want = cfg.single_shunt ? {3{~|hsg}}
                                              : ~hsg;
      CSG_MODE_ON:    want = 3'h7;
      default:        want = 3'h0;
    endcase
    st_nxt.conn = blanking ? 3'h0 : (want & cfg.amp_en);

    // Cycle-by-cycle truncation
    if (st_r.cyc2) begin
      st_nxt.trunc = 1'b0;
    end
    if (st_r.ev2 && (cfg.ocp_react == CSG_OCP_TRUNC ||
                     cfg.ocp_react == CSG_OCP_NOREP)) begin
      st_nxt.trunc = 1'b1;
    end
    st_nxt.hs_out = (st_r.trunc || st_nxt.trunc) ? 3'h0 : hsg;
    st_nxt.ls_out = lsg;
    st_nxt.brake  = (cfg.ocp_react == CSG_OCP_BRAKE) && st_r.ev2;

    // Consecutive-event count, closed at each cycle start
    cyc_ok  = st_r.cyc_ev || st_r.ev2;
    reached = 1'b0;
    if (st_r.ev2) begin
      st_nxt.cyc_ev = 1'b1;
    end
    if (st_r.cyc2) begin
      st_nxt.cyc_ev = 1'b0;
      if (!cyc_ok) begin
        st_nxt.cnt = '0;
      end else if (st_r.cnt != cfg.event_target) begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
      // One bit wider so a count of fifteen cannot wrap to zero
      reached = cyc_ok &&
        ({1'b0, st_r.cnt} + 5'h01 >= {1'b0, cfg.event_target});
    end

    // Fault: latched wins over clear, non-latched follows condition
    if (cfg.latched) begin
      if (fault_clear) begin
        st_nxt.fault = 1'b0;
        st_nxt.cnt   = '0;
      end
      if (reached) begin
        st_nxt.fault = 1'b1;
      end
    end else begin
      if (st_r.cyc2) begin
        st_nxt.fault = reached;
      end
      if (fault_clear) begin
        st_nxt.cnt = '0;
      end
    end
    if (cfg.ocp_react == CSG_OCP_DISABLE) begin
      st_nxt.fault = 1'b0;
      st_nxt.cnt   = '0;
    end
    st_nxt.fault_n = !(st_nxt.fault &&
      (cfg.ocp_react == CSG_OCP_TRUNC));

    st_nxt.gain = gain_of(cfg.gain_sel);
    st_nxt.offs = cfg.offset_sel;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_r         <= '0;
      st_r.fault_n <= 1'b1;
      st_r.gain    <= 6'h04;
      st_r.offs    <= CSG_OFFSET_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sense_output_n_conn  = st_r.conn;
  assign high_side_gate_n_out = st_r.hs_out;
  assign low_side_gate_n_out  = st_r.ls_out;
  assign brake_req            = st_r.brake;
  assign fault_out_n          = st_r.fault_n;
  assign gain_value           = st_r.gain;
  assign offset_code          = st_r.offs;

  logic hs_out_zero;
  assign hs_out_zero = (st_r.hs_out == 3'h0);

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_off_mode_quiet: assert property (@(posedge clock) disable iff (srst)
    $past(cfg.mode) == CSG_MODE_OFF && !$past(srst) |-> st_r.conn == 3'h0)
    else $error("sense connected in off mode");
  a_amp_enable_gate: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) |-> (st_r.conn & ~$past(cfg.amp_en)) == 3'h0)
    else $error("disabled amplifier connected");
  a_trunc_hs_off: assert property (@(posedge clock) disable iff (srst)
    st_r.ev2 && cfg.ocp_react == CSG_OCP_TRUNC |=> hs_out_zero)
    else $error("high side not truncated");
  a_brake_follow: assert property (@(posedge clock) disable iff (srst)
    st_r.ev2 && cfg.ocp_react == CSG_OCP_BRAKE |=> brake_req)
    else $error("brake not started");
  a_disable_quiet: assert property (@(posedge clock) disable iff (srst)
    cfg.ocp_react == CSG_OCP_DISABLE |=> fault_out_n)
    else $error("fault reported while disabled");
  a_norep_quiet: assert property (@(posedge clock) disable iff (srst)
    cfg.ocp_react == CSG_OCP_NOREP |=> fault_out_n)
    else $error("fault reported when suppressed");
  a_latch_hold: assert property (@(posedge clock) disable iff (srst)
    st_r.fault && cfg.latched && !fault_clear &&
    cfg.ocp_react != CSG_OCP_DISABLE |=> st_r.fault)
    else $error("latched fault dropped");
  a_clean_restart: assert property (@(posedge clock) disable iff (srst)
    st_r.cyc2 && !st_r.cyc_ev && !st_r.ev2 |=> st_r.cnt == '0)
    else $error("counter not restarted");
  a_gain_map: assert property (@(posedge clock) disable iff (srst)
    cfg.gain_sel == 3'h0 ##1 cfg.gain_sel == 3'h0 |-> gain_value == 6'h04)
    else $error("default gain wrong");

  c_trunc: cover property (@(posedge clock) st_r.trunc);
  c_fault: cover property (@(posedge clock) !fault_out_n);
  c_brake: cover property (@(posedge clock) brake_req);
  c_blank: cover property (@(posedge clock) st_r.blank != 8'h00);

endmodule : csg_core

`default_nettype wire

// *** design/csg_pkg.sv ***
// Package for current-sense gating and overcurrent response
package csg_pkg;

  // ********************************************************************
  // Connection modes
  // ********************************************************************
  typedef enum logic [1:0] {
    CSG_MODE_OFF   = 2'b00,
    CSG_MODE_LSON  = 2'b01,
    CSG_MODE_HSOFF = 2'b10,
    CSG_MODE_ON    = 2'b11
  } csg_mode_t;

  // Overcurrent reaction
  typedef enum logic [1:0] {
    CSG_OCP_TRUNC   = 2'b00,
    CSG_OCP_NOREP   = 2'b01,
    CSG_OCP_BRAKE   = 2'b10,
    CSG_OCP_DISABLE = 2'b11
  } csg_ocp_t;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CSG_CLK_NS       = 40;
  localparam int CSG_BLANK_MIN_NS = 50;
  localparam int CSG_BLANK_MAX_NS = 8000;
  // Least time rounds up, longest rounds down
  localparam int CSG_BLANK_MIN_CYC =
    (CSG_BLANK_MIN_NS + CSG_CLK_NS - 1) / CSG_CLK_NS;
  localparam int CSG_BLANK_MAX_CYC = CSG_BLANK_MAX_NS / CSG_CLK_NS;
  localparam int CSG_BLANK_W = 8;
  localparam int CSG_CNT_W   = 4;

  // ********************************************************************
  // Reset values and field codes
  // ********************************************************************
  localparam logic [2:0] CSG_GAIN_RST   = 3'h0;
  localparam logic [1:0] CSG_OFFSET_RST = 2'h0;
  localparam logic [CSG_BLANK_W-1:0] CSG_BLANK_RST = 8'h00;

  // Per-phase gate drive group
  typedef struct packed {
    logic [2:0] low_side_gate_n;
    logic [2:0] high_side_gate_n;
  } csg_gates_t;

  // Configuration group
  typedef struct packed {
    logic [2:0]             amp_en;
    csg_mode_t              mode;
    logic                   single_shunt;
    logic [CSG_BLANK_W-1:0] blank_cyc;
    logic [2:0]             gain_sel;
    logic [1:0]             offset_sel;
    csg_ocp_t               ocp_react;
    logic                   latched;
    logic [CSG_CNT_W-1:0]   event_target;
  } csg_cfg_t;

endpackage : csg_pkg

// *** tb/csg_host_model.sv ***
// Host-side PWM source model driving the gate pins and cycle marker
`timescale 1ns/1ps
`default_nettype none

module csg_host_model
  import csg_pkg::*;
#(
  parameter int PERIOD = 40,
  parameter int DEAD   = 2
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Per phase: 0 idle, 1 low on, 2 high on, 3 pwm
  input  wire logic [5:0] cmd,
  // Pins toward the device
  output var csg_gates_t  gates,
  output var logic        cycle_start
);
  int   cnt;
  int   dly [3];

  always_ff @(posedge clock) begin : drive
    logic hi;
    logic lo;
    cnt <= (srst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    cycle_start <= !srst && cnt == PERIOD - 1;
    for (int i = 0; i < 3; i++) begin
      hi = cmd[2*i+1] && (!cmd[2*i] || cnt < PERIOD / 2);
      lo = cmd[2*i] && !hi;
      // Both sides off for a dead time before the other side turns on
      if (srst || (gates.high_side_gate_n[i] && !hi) ||
          (gates.low_side_gate_n[i] && !lo)) begin
        gates.high_side_gate_n[i] <= 1'b0;
        gates.low_side_gate_n[i]  <= 1'b0;
        dly[i] <= DEAD;
      end else if (dly[i] != 0) begin
        dly[i] <= dly[i] - 1;
      end else begin
        gates.high_side_gate_n[i] <= hi;
        gates.low_side_gate_n[i]  <= lo;
      end
    end
  end
endmodule : csg_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the sense gating and overcurrent core
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import csg_pkg::*;
;
  // ****
  // Signals
  // ****
  localparam int PER = 40;
  logic        clock = 1'b0;
  logic        srst  = 1'b1;
  logic [5:0]  cmd   = 6'h00;
  logic        overcurrent_protect   = 1'b0;
  logic        clr   = 1'b0;
  logic        chk   = 1'b0;
  csg_cfg_t    cfg   = '0;
  csg_gates_t  gates;
  logic        cstart;
  logic [2:0]  conn, hs, ls, l, h;
  logic [5:0]  c, gain;
  logic [1:0]  offs;
  logic        brake, fault_n;
  logic [18:0] obs, oc_exp;
  logic [37:0] q [$];
  logic [37:0] ent;
  logic [5:0]  gtab [8] = '{6'h04, 6'h08, 6'h0C, 6'h0E,
                            6'h14, 6'h18, 6'h20, 6'h3F};
  int          mismatches = 0;
  int          cmp_count  = 0;

  assign obs = {conn, hs, ls, brake, fault_n, gain, offs};
  initial forever #20 clock = ~clock;

  csg_host_model #(.PERIOD(PER), .DEAD(2)) host (
    .clock(clock), .srst(srst), .cmd(cmd), .gates(gates),
    .cycle_start(cstart));
  csg_core DUT (
    .clock(clock), .srst(srst), .gates_in(gates),
    .pwm_cycle_start(cstart), .ocp_pos_event(overcurrent_protect), .cfg(cfg),
    .fault_clear(clr), .sense_output_n_conn(conn),
    .high_side_gate_n_out(hs), .low_side_gate_n_out(ls),
    .brake_req(brake), .fault_out_n(fault_n), .gain_value(gain),
    .offset_code(offs));

  // ****
  // Checking
  // ****
  always @(negedge clock) begin
    if (chk) begin
      ent = q.pop_front();
      cmp_count++;
      if ((obs & ent[18:0]) !== (ent[37:19] & ent[18:0])) begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time,
                 obs & ent[18:0], ent[37:19] & ent[18:0]);
      end
    end
  end

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic expect_obs(input logic [18:0] e, input logic [18:0] m);
    @(posedge clock);
    q.push_back({e, m});
    chk <= 1'b1;
    @(posedge clock);
    chk <= 1'b0;
  endtask : expect_obs

  task automatic wait_start();
    // Look only at falling edges, never in the launching time step
    for (int i = 0; i < 2 * PER; i++) begin
      @(negedge clock);
      if (cstart === 1'b1) break;
    end
    if (cstart !== 1'b1) begin
      mismatches++;
      final_report();
    end
    @(posedge clock);
  endtask : wait_start

  // Event held three cycles so a one-cycle reaction cannot slip by
  task automatic oc_cycle(input logic ev);
    cycles(4);
    overcurrent_protect <= ev;
    cycles(3);
    overcurrent_protect <= 1'b0;
    expect_obs(ev ? oc_exp : 19'h0E000, 19'h0E200);
    wait_start();
  endtask : oc_cycle

  task automatic flt(input logic f);
    cycles(4);
    expect_obs({10'h000, f, 8'h00}, 19'h00100);
  endtask : flt

  function automatic logic [2:0] exp_conn(input logic [2:0] lo,
                                          input logic [2:0] hi);
    case (cfg.mode)
      CSG_MODE_OFF:  return 3'h0;
      CSG_MODE_LSON: return cfg.amp_en & (cfg.single_shunt ? {3{|lo}} : lo);
      CSG_MODE_HSOFF: return cfg.amp_en & (cfg.single_shunt ? {3{~|hi}} : ~hi);
      default:       return cfg.amp_en;
    endcase
  endfunction : exp_conn

  initial begin
    void'($urandom(32'hDE625A40));
    cycles(20);
    srst <= 1'b0;
    expect_obs(19'h00110, 19'h003FF);
    for (int g = 0; g < 8; g++) begin
      cfg.gain_sel <= 3'(g);
      cfg.offset_sel <= 2'(g);
      cycles(3);
      expect_obs({11'h000, gtab[g], 2'(g)}, 19'h000FF);
    end
    for (int k = 0; k < 32; k++) begin
      c = 6'($urandom);
      for (int i = 0; i < 3; i++) begin
        if (c[2*i+:2] == 2'h3) c[2*i+:2] = 2'h0;
        l[i] = c[2*i+:2] == 2'h1;
        h[i] = c[2*i+:2] == 2'h2;
      end
      cmd <= c;
      cfg.mode <= csg_mode_t'(k[1:0]);
      cfg.single_shunt <= k[2];
      cfg.amp_en <= 3'($urandom);
      cycles(8);
      expect_obs({exp_conn(l, h), h, l, 10'h000}, 19'h7FC00);
    end
    cfg.mode <= CSG_MODE_ON;
    cfg.amp_en <= 3'h7;
    cfg.blank_cyc <= 8'h0A;
    cmd <= 6'h2A;
    cycles(10);
    cmd <= 6'h29;
    cycles(4);
    expect_obs(19'h00000, 19'h10000);
    cycles(25);
    expect_obs(19'h10000, 19'h10000);
    cfg.blank_cyc <= 8'h00;
    cmd <= 6'h2A;
    cfg.latched <= 1'b1;
    cfg.event_target <= 4'h1;
    oc_exp <= 19'h00000;
    wait_start();
    oc_cycle(1'b1);
    flt(1'b0);
    oc_cycle(1'b0);
    flt(1'b0);
    clr <= 1'b1;
    cycles(1);
    clr <= 1'b0;
    flt(1'b1);
    cfg.latched <= 1'b0;
    oc_cycle(1'b1);
    flt(1'b0);
    oc_cycle(1'b0);
    flt(1'b1);
    cfg.latched <= 1'b1;
    cfg.event_target <= 4'h3;
    oc_cycle(1'b1);
    oc_cycle(1'b1);
    oc_cycle(1'b0);
    oc_cycle(1'b1);
    oc_cycle(1'b1);
    flt(1'b1);
    oc_cycle(1'b1);
    flt(1'b0);
    clr <= 1'b1;
    cycles(1);
    clr <= 1'b0;
    oc_cycle(1'b1);
    flt(1'b1);
    cfg.latched <= 1'b0;
    cfg.event_target <= 4'h1;
    for (int r = 1; r < 4; r++) begin
      cfg.ocp_react <= csg_ocp_t'(r);
      oc_exp <= (r == 1) ? 19'h0 : (r == 2 ? 19'h0E200 : 19'h0E000);
      oc_cycle(1'b1);
      flt(1'b1);
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
